// *** hdl/pac_regs.vh ***
`ifndef PAC_REGS_VH
`define PAC_REGS_VH

// Register indices; byte address is four times the index
`define PAC_IDX_CTRL 6'h20
`define PAC_IDX_FLAGS 6'h21
`define PAC_IDX_CNT_HI 6'h22
`define PAC_IDX_CNT_LO 6'h23
`define PAC_IDX_CNT_WORD 6'h24
`define PAC_IDX_TSC 6'h25

// Control register fields
`define PAC_CTRL_ENABLE 6
`define PAC_CTRL_MODE 5
`define PAC_CTRL_EDGE 4
`define PAC_CTRL_CLK_HI 3
`define PAC_CTRL_CLK_LO 2
`define PAC_CTRL_OVF_IE 1
`define PAC_CTRL_INP_IE 0
`define PAC_CTRL_MASK 8'h7f

// Flag register fields
`define PAC_FLAG_OVF 1
`define PAC_FLAG_INP 0

// Timer system control fields
`define PAC_TSC_TIMER_EN 0
`define PAC_TSC_FFC 1

// Clock select encodings
`define PAC_CLK_PRESCALER 2'b00
`define PAC_CLK_ACCUM 2'b01
`define PAC_CLK_ACCUM_256 2'b10
`define PAC_CLK_ACCUM_65536 2'b11

// Reset values and count limits
`define PAC_CTRL_RESET 8'h00
`define PAC_CNT_RESET 16'h0000
`define PAC_TSC_RESET 2'b00
`define PAC_CNT_MAX 16'hffff
`define PAC_BYTE_MAX 8'hff

// Gating clock divisor
`define PAC_GATE_DIV 64

`endif

// *** hdl/pac_accum.v ***
// Behaviour
// - Event-mode accumulator runs regardless of timer enable
// - Mode bit picks event or gated
// - Edge select picks falling or rising edge
// - Gated: active level gates div-64 clock
// - Div-64 clock exists only with timer enabled
// - Clock select feeds main timer counter
// - Disabled accumulator forces prescaler clock
// - Clock select switch takes effect immediately
// - Overflow interrupt when flag and enable
// - Input interrupt when flag and enable
// - Overflow flag on wrap to zero
// - Writing one clears overflow flag
// - Input flag on counting or trailing edge
// - Writing one clears input flag
// - Fast clear: count access clears flags
// - Count readable and writable as bytes
// - Pin synchronised before counting
// - Enable routes channel 7 pin here
// - Interrupt requests are active high outputs
//
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
`include "pac_regs.vh"

module pac_accum #(
    parameter ADR_W = 8,
    parameter DIV_W = 6
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire channel7_pin_i,
    input wire prescaler_tick_i,
    output wire timer_count_tick_o,
    output wire accum_owns_pin_o,
    output wire irq_overflow_o,
    output wire irq_input_o
);

    localparam integer DIV_LAST_I = `PAC_GATE_DIV - 1;
    localparam [DIV_W-1:0] DIV_LAST = DIV_LAST_I[DIV_W-1:0];

    reg pin_s1_r;
    reg pin_s2_r;
    reg pin_d_r;
    reg [1:0] sync_age_r;
    reg [7:0] ctrl_r;
    reg [7:0] ctrl_nxt;
    reg [1:0] tsc_r;
    reg [1:0] tsc_nxt;
    reg ovf_r;
    reg ovf_nxt;
    reg inp_r;
    reg inp_nxt;
    reg [15:0] count_r;
    reg [15:0] count_nxt;
    reg [DIV_W-1:0] div_cnt_r;
    reg div_tick_r;
    reg ack_r;
    reg [31:0] dat_r;
    reg [31:0] dat_nxt;
    reg tick_r;
    reg tick_nxt;
    reg owns_r;

    wire [5:0] reg_idx;
    wire req;
    wire fire;
    wire wr;
    wire hit_ctrl;
    wire hit_flags;
    wire hit_hi;
    wire hit_lo;
    wire hit_word;
    wire hit_tsc;
    wire hit_count;
    wire accum_en;
    wire mode_gated;
    wire edge_rising;
    wire [1:0] clk_sel;
    wire timer_en;
    wire fast_clear;
    wire pin_rise;
    wire pin_fall;
    wire sel_edge;
    wire level_active;
    wire accum_tick;
    wire count_load;
    wire wrap_full;
    wire wrap_byte;
    wire set_ovf;
    wire set_inp;
    wire sync_ok;
    wire wr_ctrl;
    wire wr_tsc;
    wire wr_flags;
    wire clr_ovf_wr;
    wire clr_inp_wr;
    wire clr_fast;
    wire ld_hi;
    wire ld_lo;
    wire ld_word_hi;
    wire ld_word_lo;
    wire [1:0] flag_nxt_v;
    wire [1:0] ie_nxt_v;
    wire [1:0] irq_v;

    assign reg_idx = wb_adr_i[7:2];
    assign req = wb_cyc_i & wb_stb_i;
    // Action at the edge where the master samples ack
    assign fire = req & ack_r;
    assign wr = fire & wb_we_i;
    assign hit_ctrl = (reg_idx == `PAC_IDX_CTRL);
    assign hit_flags = (reg_idx == `PAC_IDX_FLAGS);
    assign hit_hi = (reg_idx == `PAC_IDX_CNT_HI);
    assign hit_lo = (reg_idx == `PAC_IDX_CNT_LO);
    assign hit_word = (reg_idx == `PAC_IDX_CNT_WORD);
    assign hit_tsc = (reg_idx == `PAC_IDX_TSC);
    assign hit_count = hit_hi | hit_lo | hit_word;

    assign accum_en = ctrl_r[`PAC_CTRL_ENABLE];
    assign mode_gated = ctrl_r[`PAC_CTRL_MODE];
    assign edge_rising = ctrl_r[`PAC_CTRL_EDGE];
    assign clk_sel = ctrl_r[`PAC_CTRL_CLK_HI:`PAC_CTRL_CLK_LO];
    assign timer_en = tsc_r[`PAC_TSC_TIMER_EN];
    assign fast_clear = tsc_r[`PAC_TSC_FFC];

    // Edges seen only on the synchronised copy
    // Masked until all three stages hold real pin samples, so no false edge after reset
    assign sync_ok = &sync_age_r;
    assign pin_rise = sync_ok & pin_s2_r & ~pin_d_r;
    assign pin_fall = sync_ok & ~pin_s2_r & pin_d_r;

    // Event edge and gate trailing edge coincide per edge select
    assign sel_edge = edge_rising ? pin_rise : pin_fall;
    assign level_active = edge_rising ? ~pin_s2_r : pin_s2_r;

    // Event mode needs no timer; gated mode needs the div-64 tick
    assign accum_tick = accum_en & (mode_gated ? (div_tick_r & level_active) : sel_edge);

    // Byte lanes that load the count; other lanes of the word are left alone
    assign ld_hi = hit_hi & wb_sel_i[0];
    assign ld_lo = hit_lo & wb_sel_i[0];
    assign ld_word_hi = hit_word & wb_sel_i[1];
    assign ld_word_lo = hit_word & wb_sel_i[0];
    assign count_load = wr & (ld_hi | ld_lo | ld_word_hi | ld_word_lo);
    assign wrap_full = accum_tick & ~count_load & (count_r == `PAC_CNT_MAX);
    assign wrap_byte = accum_tick & ~count_load & (count_r[7:0] == `PAC_BYTE_MAX);
    assign set_ovf = wrap_full;
    assign set_inp = accum_en & sel_edge;

    assign wr_ctrl = wr & hit_ctrl & wb_sel_i[0];
    assign wr_tsc = wr & hit_tsc & wb_sel_i[0];
    assign wr_flags = wr & hit_flags & wb_sel_i[0];
    assign clr_ovf_wr = wr_flags & wb_dat_i[`PAC_FLAG_OVF];
    assign clr_inp_wr = wr_flags & wb_dat_i[`PAC_FLAG_INP];
    // Reads count too: with fast clear set, any completed count access clears both flags
    assign clr_fast = fire & hit_count & fast_clear;

    // Pin synchroniser
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_d_r <= 1'b0;
            sync_age_r <= 2'b00;
        end else begin
            pin_s1_r <= channel7_pin_i;
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
            if (!sync_ok) begin
                sync_age_r <= sync_age_r + 2'b01;
            end
        end
    end

    // Divide-by-64 tick, held in reset while the timer is off
    // Its phase is free against the gate, so a gate window may count one tick more or less
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_r <= {DIV_W{1'b0}};
            div_tick_r <= 1'b0;
        end else if (!timer_en) begin
            div_cnt_r <= {DIV_W{1'b0}};
            div_tick_r <= 1'b0;
        end else begin
            div_tick_r <= (div_cnt_r == DIV_LAST);
            if (div_cnt_r == DIV_LAST) begin
                div_cnt_r <= {DIV_W{1'b0}};
            end else begin
                div_cnt_r <= div_cnt_r + 1'b1;
            end
        end
    end

    // Control and timer system control writes
    always @* begin
        ctrl_nxt = ctrl_r;
        tsc_nxt = tsc_r;
        if (wr_ctrl) begin
            ctrl_nxt = wb_dat_i[7:0] & `PAC_CTRL_MASK;
        end
        if (wr_tsc) begin
            tsc_nxt = wb_dat_i[1:0];
        end
    end

    // Count: software load wins over a coincident increment
    always @* begin
        count_nxt = count_r;
        if (count_load) begin
            if (hit_word) begin
                if (wb_sel_i[1]) begin
                    count_nxt[15:8] = wb_dat_i[15:8];
                end
                if (wb_sel_i[0]) begin
                    count_nxt[7:0] = wb_dat_i[7:0];
                end
            end else if (hit_hi) begin
                count_nxt[15:8] = wb_dat_i[7:0];
            end else begin
                count_nxt[7:0] = wb_dat_i[7:0];
            end
        end else if (accum_tick) begin
            count_nxt = count_r + 16'h0001;
        end
    end

    // Flags: hardware set beats any clear in the same cycle
    always @* begin
        ovf_nxt = ovf_r;
        inp_nxt = inp_r;
        if (clr_ovf_wr) begin
            ovf_nxt = 1'b0;
        end
        if (clr_inp_wr) begin
            inp_nxt = 1'b0;
        end
        if (clr_fast) begin
            ovf_nxt = 1'b0;
            inp_nxt = 1'b0;
        end
        if (set_ovf) begin
            ovf_nxt = 1'b1;
        end
        if (set_inp) begin
            inp_nxt = 1'b1;
        end
    end

    // Main timer counter clock source, from live select bits
    always @* begin
        tick_nxt = prescaler_tick_i;
        if (accum_en) begin
            case (clk_sel)
                `PAC_CLK_PRESCALER: begin
                    tick_nxt = prescaler_tick_i;
                end
                `PAC_CLK_ACCUM: begin
                    tick_nxt = accum_tick;
                end
                `PAC_CLK_ACCUM_256: begin
                    tick_nxt = wrap_byte;
                end
                `PAC_CLK_ACCUM_65536: begin
                    tick_nxt = wrap_full;
                end
                default: begin
                    tick_nxt = prescaler_tick_i;
                end
            endcase
        end else begin
            tick_nxt = prescaler_tick_i;
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        dat_nxt = 32'h0000_0000;
        if (hit_ctrl) begin
            dat_nxt[7:0] = ctrl_r;
        end else if (hit_flags) begin
            dat_nxt[`PAC_FLAG_OVF] = ovf_r;
            dat_nxt[`PAC_FLAG_INP] = inp_r;
        end else if (hit_hi) begin
            dat_nxt[7:0] = count_r[15:8];
        end else if (hit_lo) begin
            dat_nxt[7:0] = count_r[7:0];
        end else if (hit_word) begin
            dat_nxt[15:0] = count_r;
        end else if (hit_tsc) begin
            dat_nxt[1:0] = tsc_r;
        end
    end

    // Register state
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `PAC_CTRL_RESET;
            tsc_r <= `PAC_TSC_RESET;
            count_r <= `PAC_CNT_RESET;
            ovf_r <= 1'b0;
            inp_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            tsc_r <= tsc_nxt;
            count_r <= count_nxt;
            ovf_r <= ovf_nxt;
            inp_r <= inp_nxt;
        end
    end

    // Bus answer: ack one cycle after request, dropped after one cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req & ~ack_r;
            if (req && !ack_r) begin
                dat_r <= dat_nxt;
            end
        end
    end

    // Registered outputs to timer, pin mux and interrupt controller
    always @(posedge clk_i) begin
        if (rst_i) begin
            tick_r <= 1'b0;
            owns_r <= 1'b0;
        end else begin
            tick_r <= tick_nxt;
            owns_r <= ctrl_nxt[`PAC_CTRL_ENABLE];
        end
    end

    // One request line per flag: index 1 overflow, index 0 input
    assign flag_nxt_v = {ovf_nxt, inp_nxt};
    assign ie_nxt_v = {ctrl_nxt[`PAC_CTRL_OVF_IE], ctrl_nxt[`PAC_CTRL_INP_IE]};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
            reg req_r;
            always @(posedge clk_i) begin
                if (rst_i) begin
                    req_r <= 1'b0;
                end else begin
                    req_r <= flag_nxt_v[gi] & ie_nxt_v[gi];
                end
            end
            assign irq_v[gi] = req_r;
        end
    endgenerate

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign timer_count_tick_o = tick_r;
    assign accum_owns_pin_o = owns_r;
    assign irq_overflow_o = irq_v[1];
    assign irq_input_o = irq_v[0];

endmodule // pac_accum

// *** tb/pac_accum_sva.sv ***
`timescale 1ns/100ps
module pac_accum_sva #(
    parameter ADR_W = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire channel7_pin_i,
    input wire prescaler_tick_i,
    input wire timer_count_tick_o,
    input wire accum_owns_pin_o,
    input wire irq_overflow_o,
    input wire irq_input_o
);
    // Shadow of the control bits, taken at the write's ack edge
    reg [6:0] ctl_r;
    wire ctl_hit = wb_adr_i[7:2] == 6'h20;
    wire ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && ctl_hit;
    always @(posedge clk_i) begin
        ctl_r <= rst_i ? 7'h00 : ctl_wr ? wb_dat_i[6:0] : ctl_r;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bus request not answered");
    property p_own; accum_owns_pin_o == ctl_r[6]; endproperty
    a_own: assert property (p_own) else $error("pin routing differs from enable");
    property p_iov; irq_overflow_o |-> ctl_r[1]; endproperty
    a_iov: assert property (p_iov) else $error("overflow request while masked");
    property p_iin; irq_input_o |-> ctl_r[0]; endproperty
    a_iin: assert property (p_iin) else $error("input request while masked");
    property p_pre; (!ctl_r[6] || ctl_r[3:2] == 2'b00) && $stable(ctl_r)
        |=> timer_count_tick_o == $past(prescaler_tick_i); endproperty
    a_pre: assert property (p_pre) else $error("timer tick not from prescaler");
    property p_sw; ctl_r[6] && ctl_r[3:2] == 2'b00 && $past(ctl_r[3:2]) != 2'b00
        |=> timer_count_tick_o == $past(prescaler_tick_i); endproperty
    a_sw: assert property (p_sw) else $error("clock switch delayed");
    // Pin quiet long enough that no edge is still in the synchroniser
    property p_quiet; (ctl_r[6] && !ctl_r[5] && ctl_r[3:2] != 2'b00 && $stable(channel7_pin_i)) [*5]
        |=> !timer_count_tick_o; endproperty
    a_quiet: assert property (p_quiet) else $error("timer tick without events");
    property p_rd; wb_ack_o && !wb_we_i && ctl_hit |-> wb_dat_o[7:0] == {1'b0, ctl_r}; endproperty
    a_rd: assert property (p_rd) else $error("control readback wrong");
    c_inp: cover property ($rose(irq_input_o));
    c_ovf: cover property ($rose(irq_overflow_o));
    c_div: cover property (ctl_r[3:2] == 2'b10 && timer_count_tick_o);
endmodule // pac_accum_sva

// *** tb/pac_pin_src.sv ***
`timescale 1ns/100ps
module pac_pin_src (
    input wire clk_i,
    output logic pin_o
);
    initial pin_o = 1'b1;
    // Four-cycle phases keep every level well above the synchroniser minimum
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            pin_o <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
    endtask
    task automatic gate(input int n);
        @(posedge clk_i);
        pin_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        pin_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
endmodule // pac_pin_src

// *** tb/test_pulse_accumulator_16bit.sv ***
`timescale 1ns/100ps
module test_pulse_accumulator_16bit;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, ws = 4'hf;
    logic [31:0] dat = 32'h0, q, dato;
    logic ack, tco, own, iov, iin, pin;
    logic [1:0] pc = 2'h0;
    int fail_count = 0, cmp_count = 0, nt = 0, n0;
    pac_accum DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack),
        .channel7_pin_i(pin), .prescaler_tick_i(tick), .timer_count_tick_o(tco),
        .accum_owns_pin_o(own), .irq_overflow_o(iov), .irq_input_o(iin));
    pac_pin_src SRC (.clk_i(clk), .pin_o(pin));
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        pc <= pc + 2'h1;
        tick <= pc == 2'h3;
        if (tco === 1'b1) nt <= nt + 1;
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, ws, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) fail_count++;
        q = dato;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("mismatches %0d, comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_event;
        wb(1'b1, 8'h80, 32'h40);
        SRC.pulses(3);
        chk("pin owned", 32'h1, own);
        wb(1'b0, 8'h90, 32'h0);
        chk("count falling", 32'h3, q);
        wb(1'b0, 8'h84, 32'h0);
        chk("flags", 32'h1, q);
        wb(1'b1, 8'h80, 32'h51);
        wb(1'b1, 8'h90, 32'h0);
        SRC.pulses(2);
        wb(1'b0, 8'h90, 32'h0);
        chk("count rising", 32'h2, q);
        chk("input irq", 32'h1, iin);
        wb(1'b1, 8'h84, 32'h1);
        #1 chk("input irq clr", 32'h0, iin);
    endtask
    task automatic t_wrap;
        wb(1'b1, 8'h80, 32'h42);
        wb(1'b1, 8'h90, 32'hfffe);
        SRC.pulses(3);
        wb(1'b0, 8'h90, 32'h0);
        chk("count wrap", 32'h1, q);
        chk("ovf irq", 32'h1, iov);
        wb(1'b1, 8'h80, 32'h40);
        #1 chk("ovf irq masked", 32'h0, iov);
        wb(1'b1, 8'h84, 32'h2);
        wb(1'b0, 8'h84, 32'h0);
        chk("ovf cleared", 32'h1, q);
    endtask
    task automatic t_regs;
        wb(1'b1, 8'h88, 32'h12);
        wb(1'b1, 8'h8c, 32'h34);
        wb(1'b0, 8'h90, 32'h0);
        chk("count word", 32'h1234, q);
        ws = 4'he;
        wb(1'b1, 8'h88, 32'hff);
        ws = 4'h1;
        wb(1'b1, 8'h90, 32'habcd);
        ws = 4'hf;
        wb(1'b0, 8'h90, 32'h0);
        chk("byte lanes", 32'h12cd, q);
        wb(1'b1, 8'hfc, 32'hff);
        wb(1'b0, 8'hfc, 32'h0);
        chk("unmapped", 32'h0, q);
        wb(1'b1, 8'h94, 32'h2);
        wb(1'b0, 8'h8c, 32'h0);
        wb(1'b0, 8'h84, 32'h0);
        chk("fast clear", 32'h0, q);
        wb(1'b1, 8'h94, 32'h0);
    endtask
    task automatic t_clk;
        wb(1'b1, 8'h80, 32'h44);
        @(posedge clk);
        #1 n0 = nt;
        SRC.pulses(5);
        chk("tick accum", 32'd5, nt - n0);
        wb(1'b1, 8'h80, 32'h48);
        wb(1'b1, 8'h90, 32'hfe);
        n0 = nt;
        SRC.pulses(3);
        chk("tick div", 32'd1, nt - n0);
        wb(1'b1, 8'h80, 32'h40);
    endtask
    task automatic t_gated;
        wb(1'b1, 8'h80, 32'h70);
        wb(1'b1, 8'h90, 32'h0);
        SRC.gate(200);
        wb(1'b0, 8'h90, 32'h0);
        chk("gated timer off", 32'h0, q);
        wb(1'b1, 8'h94, 32'h1);
        wb(1'b1, 8'h84, 32'h3);
        SRC.gate(200);
        wb(1'b0, 8'h90, 32'h0);
        chk("gated count", 32'h1, q >= 32'h3 && q <= 32'h4);
        wb(1'b0, 8'h84, 32'h0);
        chk("gated flag", 32'h1, q);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, 8'h80, 32'h0);
        chk("ctrl reset", 32'h0, q);
        chk("pin free", 32'h0, own);
        t_event;
        t_wrap;
        t_regs;
        t_clk;
        t_gated;
        end_sim;
    end
    // Whole run is under a thousand cycles
    initial begin
        #1000000;
        fail_count++;
        end_sim;
    end
endmodule // test_pulse_accumulator_16bit
bind pac_accum pac_accum_sva #(.ADR_W(ADR_W)) u_sva (.*);
